// File: verilog/sdb_pkg.sv
package sdb_pkg;

    // ----------------------------------------------------------------
    // register map (word offsets on the bus)
    // ----------------------------------------------------------------
    localparam logic [3:0] DATA_OFF   = 4'h0;   // serial_data_reg
    localparam logic [3:0] STATUS_OFF = 4'h4;   // serial_status_reg
    localparam logic [3:0] CTRL_OFF   = 4'h8;   // serial_control_reg
    localparam logic [3:0] CMD_OFF    = 4'hc;   // serial_command_reg

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ST_OVERRUN_BIT  = 0;         // overrun_flag
    localparam int ST_TX_EMPTY_BIT = 1;         // tx_empty_flag
    localparam int ST_RX_FULL_BIT  = 2;         // rx_full_flag
    localparam int ST_SR_EMPTY_BIT = 3;         // shift register empty
    localparam int ST_BUSY_BIT     = 4;         // frame in progress

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DATA_RST  = 16'h0000;
    localparam logic [2:0]  CTRL_RST  = 3'h0;
    localparam logic [5:0]  CMD_RST   = 6'h0f;  // 16 bits, msb first, clock idles low

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic rx_irq_enable;                    // bit 2
        logic tx_irq_enable;                    // bit 1
        logic port_enable;                      // bit 0
    } sdb_ctrl_t;

    typedef struct packed
    {
        logic       clock_idle_high;            // bit 5
        logic       lsb_first;                  // bit 4
        logic [3:0] len_code;                   // bits 3:0, length minus one
    } sdb_cmd_t;

    // serial engine states, one-hot
    typedef enum logic [1:0]
    {
        SDB_IDLE  = 2'b01,
        SDB_SHIFT = 2'b10
    } sdb_state_t;

endpackage : sdb_pkg

// File: verilog/sdb_data_path.sv
// Contract
// - data is bit zero up to configured length
// - load full shift register from tx buffer
// - 16-bit msb first: out bit 15, in bit 0
// - 10-bit msb first: bits 15..10 retained
// - lsb first reverses on load and on copy
// - 10-bit lsb first: out 15, in 6
// - at end copy to rx, mark shift empty
// - unloaded transfer resends previous shift contents
// - write to empty buffer stores, clears tx empty
// - empty shift register takes buffer, sets tx empty
// - busy shift register keeps new data buffered
// - end with rx empty copies, sets rx full
// - end with tx full reloads shift register
// - overrun still frees the shift register
// - data read returns rx buffer, clears full
// - writes ignored while tx empty is zero
// - tx interrupt from tx empty and enable
// - disabled port forces tx empty to one
// - end with rx full is overrun, no copy
// - rx interrupt from rx full and enable
// - overrun flag set blocks all rx copies
// - overrun clears by read-then-write-zero or reset
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
module sdb_data_path
#(
    parameter int DATA_W = 16                           // shift register width
)
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    // wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // serial side
    input  wire logic        serial_clock_pin_in,
    input  wire logic        select_n_in,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    // interrupt requests
    output logic             tx_irq_out,
    output logic             rx_irq_out
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (DATA_W != 16)
    begin : g_width_check
        $error("sdb_data_path: only a 16-bit shift register is supported");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // plain bit reversal of a word
    function automatic logic [15:0] bit_reverse(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // one shift step over the active window only; the rest keeps its bits
    function automatic logic [15:0] shift_step(input logic [15:0] sr,
                                               input logic [4:0]  len,
                                               input logic        lsb,
                                               input logic        din);
        logic [15:0] n;
        int          lo;
        n  = sr;
        lo = lsb ? 16 - int'(len) : 0;
        for (int i = 0; i < 16; i++)
        begin
            if (i >= lo && i < lo + int'(len))
            begin
                n[i] = (i == lo) ? din : sr[i - 1];
            end
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    sdb_pkg::sdb_ctrl_t  ctrl;                          // serial_control_reg
    sdb_pkg::sdb_cmd_t   cmd;                           // serial_command_reg
    sdb_pkg::sdb_state_t state;                         // serial engine
    logic [15:0] tx_buf;                                // transmit buffer
    logic [15:0] rx_buf;                                // receive buffer
    logic [15:0] shift_reg;                             // shift register
    logic        tx_empty_flag;                         // buffer free for a write
    logic        rx_full_flag;                          // unread data waiting
    logic        overrun_flag;                          // receive lost
    logic        ovr_armed;                             // status read saw overrun
    logic        shift_empty;                           // shift register free
    logic [4:0]  bit_cnt;                               // bits shifted so far
    logic [2:0]  sclk_sync;                             // 2-ff sync plus edge history
    logic [1:0]  sel_sync;                              // 2-ff sync of select
    logic [1:0]  din_sync;                              // 2-ff sync of data in

    // ----------------------------------------------------------------
    // derived terms
    // ----------------------------------------------------------------
    logic        bus_req;                               // new bus cycle this edge
    logic        wr_data;                               // data register write
    logic        rd_data;                               // data register read
    logic        wr_status;                             // status register write
    logic        rd_status;                             // status register read
    logic [4:0]  active_len;                            // bits per transfer
    logic        sclk_now;                              // polarity-corrected clock
    logic        sclk_prev;
    logic        sample_edge;                           // leading edge inside a frame
    logic        selected;                              // frame active, port on
    logic        xfer_end;                              // last bit sampled
    logic        load_shift;                            // buffer moves to shift reg
    logic [15:0] next_tx_buf;

    assign bus_req     = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_data     = bus_req && wb_we_in && (wb_adr_in == sdb_pkg::DATA_OFF);
    assign rd_data     = bus_req && !wb_we_in && (wb_adr_in == sdb_pkg::DATA_OFF);
    assign wr_status   = bus_req && wb_we_in && (wb_adr_in == sdb_pkg::STATUS_OFF);
    assign rd_status   = bus_req && !wb_we_in && (wb_adr_in == sdb_pkg::STATUS_OFF);
    // length code plus one gives 1 to 16 bits
    assign active_len  = {1'b0, cmd.len_code} + 5'h01;
    assign sclk_now    = sclk_sync[1] ^ cmd.clock_idle_high;
    assign sclk_prev   = sclk_sync[2] ^ cmd.clock_idle_high;
    assign selected    = !sel_sync[1] && ctrl.port_enable;
    assign sample_edge = selected && sclk_now && !sclk_prev;
    assign xfer_end    = sample_edge && (bit_cnt == active_len - 5'h01);
    // only between frames, so a running transfer keeps its data
    // after a frame ends this reloads a buffer that waited
    assign load_shift  = !tx_empty_flag && shift_empty && (state == sdb_pkg::SDB_IDLE);

    // byte-lane merge of a data write into the transmit buffer
    always_comb
    begin
        next_tx_buf = tx_buf;
        if (wb_sel_in[0])
        begin
            next_tx_buf[7:0] = wb_dat_in[7:0];
        end
        if (wb_sel_in[1])
        begin
            next_tx_buf[15:8] = wb_dat_in[15:8];
        end
    end

    // ----------------------------------------------------------------
    // synchronisers: first stage feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            sclk_sync <= 3'h0;
            sel_sync  <= 2'h3;
            din_sync  <= 2'h0;
        end
        else
        begin
            sclk_sync <= {sclk_sync[1:0], serial_clock_pin_in};
            sel_sync  <= {sel_sync[0], select_n_in};
            din_sync  <= {din_sync[0], serial_data_in};
        end
    end

    // ----------------------------------------------------------------
    // control and command registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            ctrl <= sdb_pkg::CTRL_RST;
            cmd  <= sdb_pkg::CMD_RST;
        end
        else if (bus_req && wb_we_in && wb_sel_in[0])
        begin
            // writes to command take effect at once, even mid-frame, so a change during a frame
            // moves the shift window under the running transfer
            if (wb_adr_in == sdb_pkg::CTRL_OFF)
            begin
                ctrl <= wb_dat_in[2:0];
            end
            else if (wb_adr_in == sdb_pkg::CMD_OFF)
            begin
                cmd <= wb_dat_in[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer and its empty flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            tx_buf        <= sdb_pkg::DATA_RST;
            tx_empty_flag <= 1'b1;
        end
        else if (!ctrl.port_enable)
        begin
            tx_empty_flag <= 1'b1;
            if (wr_data)
            begin
                tx_buf <= next_tx_buf;
            end
        end
        else if (wr_data && tx_empty_flag)
        begin
            tx_buf        <= next_tx_buf;
            tx_empty_flag <= 1'b0;
        end
        else if (load_shift)
        begin
            tx_empty_flag <= 1'b1;
        end
        // a write while the flag is low falls through unchanged
    end

    // ----------------------------------------------------------------
    // serial engine state and bit counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            state   <= sdb_pkg::SDB_IDLE;
            bit_cnt <= 5'h00;
        end
        else
        begin
            case (state)
                sdb_pkg::SDB_IDLE:
                begin
                    bit_cnt <= 5'h00;
                    // not while a load is pending, so the frame sees fresh data
                    if (selected && !load_shift)
                    begin
                        state <= sdb_pkg::SDB_SHIFT;
                    end
                end
                sdb_pkg::SDB_SHIFT:
                begin
                    if (!selected)
                    begin
                        // frame dropped early: abandon, no copy
                        state   <= sdb_pkg::SDB_IDLE;
                        bit_cnt <= 5'h00;
                    end
                    else if (xfer_end)
                    begin
                        state   <= sdb_pkg::SDB_IDLE;
                        bit_cnt <= 5'h00;
                    end
                    else if (sample_edge)
                    begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                default:
                begin
                    state   <= sdb_pkg::SDB_IDLE;
                    bit_cnt <= 5'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // shift register and its empty mark
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            shift_reg   <= sdb_pkg::DATA_RST;
            shift_empty <= 1'b1;
        end
        else if (load_shift)
        begin
            // whole register is filled, lsb first reversed
            shift_reg   <= cmd.lsb_first ? bit_reverse(tx_buf) : tx_buf;
            shift_empty <= 1'b0;
        end
        else if (state == sdb_pkg::SDB_SHIFT && sample_edge)
        begin
            // msb first: window len-1..0, lsb first: 15..16-len
            // an unloaded frame just shifts the old contents out
            shift_reg <= shift_step(shift_reg, active_len, cmd.lsb_first, din_sync[1]);
            if (xfer_end)
            begin
                shift_empty <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // receive buffer, full flag and overrun
    // ----------------------------------------------------------------
    logic [15:0] rx_word;                               // word as it lands in rx
    logic [15:0] end_shift;                             // shift reg after last bit
    logic        rx_copy;                               // end of frame, copy allowed
    assign end_shift = shift_step(shift_reg, active_len, cmd.lsb_first, din_sync[1]);
    assign rx_word   = cmd.lsb_first ? bit_reverse(end_shift) : end_shift;
    assign rx_copy   = xfer_end && (state == sdb_pkg::SDB_SHIFT)
                       && !rx_full_flag && !overrun_flag;

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            rx_buf       <= sdb_pkg::DATA_RST;
            rx_full_flag <= 1'b0;
        end
        else if (rx_copy)
        begin
            // set wins over a read clearing in the same cycle
            rx_buf       <= rx_word;
            rx_full_flag <= 1'b1;
        end
        else if (rd_data && rx_full_flag)
        begin
            rx_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            overrun_flag <= 1'b0;
            ovr_armed    <= 1'b0;
        end
        else if (xfer_end && state == sdb_pkg::SDB_SHIFT && rx_full_flag)
        begin
            overrun_flag <= 1'b1;
        end
        else if (wr_status && wb_sel_in[0] && !wb_dat_in[sdb_pkg::ST_OVERRUN_BIT]
                 && ovr_armed)
        begin
            overrun_flag <= 1'b0;
            ovr_armed    <= 1'b0;
        end
        else if (rd_status && overrun_flag)
        begin
            ovr_armed <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // wishbone answer: one wait state, registered data
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_out <= bus_req;
            wb_dat_out <= 32'h0000_0000;
            if (bus_req && !wb_we_in)
            begin
                case (wb_adr_in)
                    sdb_pkg::DATA_OFF:
                    begin
                        wb_dat_out[15:0] <= rx_buf;
                    end
                    sdb_pkg::STATUS_OFF:
                    begin
                        wb_dat_out[sdb_pkg::ST_OVERRUN_BIT]  <= overrun_flag;
                        wb_dat_out[sdb_pkg::ST_TX_EMPTY_BIT] <= tx_empty_flag;
                        wb_dat_out[sdb_pkg::ST_RX_FULL_BIT]  <= rx_full_flag;
                        wb_dat_out[sdb_pkg::ST_SR_EMPTY_BIT] <= shift_empty;
                        wb_dat_out[sdb_pkg::ST_BUSY_BIT]     <= (state == sdb_pkg::SDB_SHIFT);
                    end
                    sdb_pkg::CTRL_OFF:
                    begin
                        wb_dat_out[2:0] <= ctrl;
                    end
                    sdb_pkg::CMD_OFF:
                    begin
                        wb_dat_out[5:0] <= cmd;
                    end
                    default:
                    begin
                        wb_dat_out <= 32'h0000_0000;                    // unmapped reads zero
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // serial output and interrupt levels, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            serial_data_out <= 1'b0;
            tx_irq_out      <= 1'b0;
            rx_irq_out      <= 1'b0;
        end
        else
        begin
            // output bit is the top of the active window
            serial_data_out <= cmd.lsb_first ? shift_reg[15] : shift_reg[cmd.len_code];
            tx_irq_out      <= tx_empty_flag && ctrl.tx_irq_enable;
            rx_irq_out      <= rx_full_flag && ctrl.rx_irq_enable;
        end
    end

endmodule // sdb_data_path

// File: dv/sdb_data_path_properties.sv
module sdb_data_path_checker
(
    // bus side
    input wire logic        clk_sys_in,
    input wire logic        reset_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [3:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    // serial and interrupt side
    input wire logic        serial_clock_pin_in,
    input wire logic        select_n_in,
    input wire logic        serial_data_in,
    input wire logic        serial_data_out,
    input wire logic        tx_irq_out,
    input wire logic        rx_irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;                                 // request taken at this edge
    assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    // ----------------------------------------
    // bus answer and interrupt levels
    // ----------------------------------------
    ack_one_wait_a: assert property (take |=> wb_ack_out)
        else $error("ack missing after request");
    ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held over two cycles");
    ack_unasked_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack without request");
    dat_quiet_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data outside ack");
    upper_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0)
        else $error("upper read bits not zero");
    unmapped_zero_a: assert property (
        take && !wb_we_in && wb_adr_in[1:0] != 2'h0 |=> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    // a disabled port still reports an empty tx buffer
    tx_irq_off_a: assert property (
        take && wb_we_in && wb_sel_in[0] && wb_adr_in == sdb_pkg::CTRL_OFF
        && wb_dat_in[1:0] == 2'h2 |-> ##[1:5] tx_irq_out) else $error("no tx irq");
    rx_irq_clear_a: assert property (
        rx_irq_out && take && !wb_we_in && wb_adr_in == sdb_pkg::DATA_OFF
        |-> ##[1:5] !rx_irq_out) else $error("rx irq not cleared by read");
endmodule // sdb_data_path_checker

bind sdb_data_path sdb_data_path_checker sdb_data_path_checker_inst (.*);

// File: dv/sdb_spi_master_model.sv
module sdb_spi_master_model
(
    // serial lines toward the block
    output logic            sclk_out,
    output logic            sel_n_out,
    output logic            mosi_out,
    input  wire logic       miso_in
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam real HALF = 62.5;                // half of the 125 ns link period
    logic idle_high = 1'b0;                     // clock level between frames, set by the bench
    // clock stands at its idle level outside frames
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // one frame; bit index order follows the chosen bit order
    task automatic frame(input logic [15:0] tx, input int n, input logic lsb,
                         output logic [15:0] rx);
        int idx;
        rx = 16'h0000;
        sclk_out = idle_high;
        sel_n_out = 1'b0;
        #(4 * HALF);
        for (int i = 0; i < n; i++)
        begin
            idx = lsb ? i : n - 1 - i;
            mosi_out = tx[idx];
            #HALF;
            rx[idx] = miso_in;                  // sampled just before the leading edge
            sclk_out = ~idle_high;
            #HALF;
            sclk_out = idle_high;
        end
        #(2 * HALF);
        sel_n_out = 1'b1;
        mosi_out = ~mosi_out;                   // released line shows no stale bit
        #(4 * HALF);                            // gap between frames
    endtask
endmodule // sdb_spi_master_model

// File: dv/tb.sv
`define CHK(name, exp, got) \
    begin \
        comparisons = comparisons + 1; \
        if ((got) !== (exp)) \
        begin \
            errors = errors + 1; \
            $display("wrong value %s expected %h seen %h", name, exp, got); \
        end \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in;
    logic        reset_in;
    logic        req;                           // cyc and stb rise together
    logic        wb_we;
    logic [3:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        sclk, sel_n, mosi, miso, tx_irq, rx_irq;
    int          errors = 0;
    int          comparisons = 0;
    sdb_data_path sdb_data_path_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
        .serial_clock_pin_in(sclk), .select_n_in(sel_n), .serial_data_in(mosi),
        .serial_data_out(miso), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
    sdb_spi_master_model sdb_spi_master_model_inst (.sclk_out(sclk), .sel_n_out(sel_n),
        .mosi_out(mosi), .miso_in(miso));
    // ----------------------------------------
    // bus cycles and checks
    // ----------------------------------------
    task automatic bus(input logic we, input logic [3:0] adr, input logic [15:0] wd,
                       output logic [15:0] rd);
        int n = 0;
        @(posedge clk_sys_in);
        req <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= {16'h0000, wd};
        do @(posedge clk_sys_in); while (wb_ack !== 1'b1 && ++n < 20);
        `CHK("bus ack", 1'b1, wb_ack)
        rd = wb_rdat[15:0];                     // taken at the ack edge only
        req <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] adr, input logic [15:0] wd);
        logic [15:0] unused;
        bus(1'b1, adr, wd, unused);
    endtask
    task automatic rd_chk(input string name, input logic [3:0] adr, input logic [15:0] exp);
        logic [15:0] got;
        bus(1'b0, adr, 16'h0000, got);
        `CHK(name, exp, got)
    endtask
    task automatic frame_chk(input logic [15:0] tx, input int n, input logic lsb,
                             input logic [15:0] exp);
        logic [15:0] got;
        sdb_spi_master_model_inst.frame(tx, n, lsb, got);
        `CHK("serial out", exp, got)
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // hang guard, several times the expected run
    initial
    begin
        #200us;
        errors = errors + 1;
        final_report();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        reset_in = 1'b1;
        req = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_sel = 4'hf;
        wb_wdat = 32'h0;
        repeat (4) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h000a);
        rd_chk("command", sdb_pkg::CMD_OFF, 16'h000f);
        rd_chk("unmapped", 4'h2, 16'h0000);
        wr(sdb_pkg::CTRL_OFF, 16'h0002);
        repeat (4) @(posedge clk_sys_in);
        `CHK("tx irq", 1'b1, tx_irq)
        wr(sdb_pkg::CTRL_OFF, 16'h0005);
        wr(sdb_pkg::DATA_OFF, 16'ha5c3);
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h0002);
        frame_chk(16'h1234, 16, 1'b0, 16'ha5c3);
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h000e);
        `CHK("rx irq", 1'b1, rx_irq)
        rd_chk("data", sdb_pkg::DATA_OFF, 16'h1234);
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h000a);
        frame_chk(16'h0f0f, 16, 1'b0, 16'h1234);
        rd_chk("data", sdb_pkg::DATA_OFF, 16'h0f0f);
        // writes land while the shift register is busy
        fork
            frame_chk(16'h6666, 16, 1'b0, 16'h0f0f);
            begin
                repeat (20) @(posedge clk_sys_in);
                wr(sdb_pkg::DATA_OFF, 16'h1111);
                wr(sdb_pkg::DATA_OFF, 16'h2222);
                // busy, buffer held, shift register never loaded for this frame
                rd_chk("status", sdb_pkg::STATUS_OFF, 16'h0018);
            end
        join
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h0006);
        rd_chk("data", sdb_pkg::DATA_OFF, 16'h6666);
        // receive buffer left full on purpose
        frame_chk(16'haaaa, 16, 1'b0, 16'h1111);
        wr(sdb_pkg::DATA_OFF, 16'h3c3c);
        frame_chk(16'h5555, 16, 1'b0, 16'h3c3c);
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h000f);
        rd_chk("data", sdb_pkg::DATA_OFF, 16'haaaa);
        frame_chk(16'h7777, 16, 1'b0, 16'h5555);
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h000b);
        wr(sdb_pkg::STATUS_OFF, 16'h0000);
        rd_chk("status", sdb_pkg::STATUS_OFF, 16'h000a);
        wr(sdb_pkg::CMD_OFF, 16'h0019);
        wr(sdb_pkg::DATA_OFF, 16'hfeb5);
        frame_chk(16'h0155, 10, 1'b1, 16'h02b5);
        rd_chk("data", sdb_pkg::DATA_OFF, 16'hfd55);
        wr(sdb_pkg::CMD_OFF, 16'h0009);
        wr(sdb_pkg::DATA_OFF, 16'h8136);
        frame_chk(16'h02c9, 10, 1'b0, 16'h0136);
        rd_chk("data", sdb_pkg::DATA_OFF, 16'h82c9);
        // clock idling high: the falling pin edge is the leading one
        wr(sdb_pkg::CMD_OFF, 16'h002f);
        sdb_spi_master_model_inst.idle_high = 1'b1;
        wr(sdb_pkg::DATA_OFF, 16'h5a3c);
        frame_chk(16'hc3a5, 16, 1'b0, 16'h5a3c);
        rd_chk("data", sdb_pkg::DATA_OFF, 16'hc3a5);
        final_report();
    end
endmodule // tb
